/* File: inc/sdc_pkg.sv */
// Purpose: Constants, register map and carrier types for the serial divider/control slice
// Assumes: Plain register port, 16-bit register data, full 32-bit byte addresses
// Notes:   Status, mask, control and receive-pop registers sit above the three data/setup registers

package sdc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] OFS_TX_DATA   = 32'h40030008;
	localparam logic [31:0] OFS_DIV_CTRL  = 32'h4003000c;
	localparam logic [31:0] OFS_UNIT_CFG  = 32'h40030010;
	localparam logic [31:0] OFS_UNIT_CTRL = 32'h40030020;
	localparam logic [31:0] OFS_STATUS    = 32'h40030024;
	localparam logic [31:0] OFS_MASK      = 32'h40030028;
	localparam logic [31:0] OFS_RX_POP    = 32'h4003002c;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int          DIV_EDGE_IRQ  = 8;
	localparam int          DIV_RESTART   = 7;
	localparam logic [15:0] DIV_RW_MASK   = 16'h01ff;
	localparam int          CFG_THR_HI    = 15;
	localparam int          CFG_THR_LO    = 14;
	localparam int          CFG_TX_PURGE  = 13;
	localparam int          CFG_RX_PURGE  = 12;
	localparam int          CFG_CONTINUOUS_MODE      = 11;
	localparam int          CFG_ZERO_FILL = 7;
	localparam int          CTL_ENABLE    = 0;
	localparam int          CTL_DMA       = 1;
	localparam int          CTL_HSPEED    = 2;
	localparam logic [15:0] REG_RESET     = 16'h0000;

	// Sticky status bits, mask has the same layout
	localparam int          ST_TX_THR     = 0;
	localparam int          ST_RX_THR     = 1;
	localparam int          ST_UNDERFLOW  = 2;
	localparam int          ST_SEL_RISE   = 3;
	localparam int          ST_SEL_FALL   = 4;
	localparam int          ST_SEL_ERR    = 5;
	localparam int          ST_W          = 6;
	localparam logic [5:0]  ST_RESET      = 6'h00;
	localparam int          ST_TXCNT_LO   = 8;
	localparam int          ST_RXCNT_LO   = 12;

	localparam int          FIFO_DEPTH    = 4;
	localparam logic [2:0]  LAST_BIT      = 3'h7;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} sdc_bus_req_t;

	typedef struct packed {
		logic sclk;
		logic mosi;
	} sdc_ser_t;

	typedef enum logic {SH_IDLE, SH_SHIFT} sdc_state_t;

endpackage

/* File: design/sdc_top.sv */
// Purpose: Transmit data, divider and configuration registers with a compact serial engine
// Assumes: CS_N and MISO synchronous to CLK_SYS; power-of-two FIFO depth
// Notes:   Mode 0 shifting, MSB first; select input gates the engine

`timescale 1ns/1ps

module sdc_top #(
	parameter int DEPTH = sdc_pkg::FIFO_DEPTH
) (
	input  wire logic                 CLK_SYS,
	input  wire logic                 RST,
	input  wire sdc_pkg::sdc_bus_req_t BUS,
	output logic [15:0]               RDATA,
	input  wire logic                 CS_N,
	input  wire logic                 MISO,
	output sdc_pkg::sdc_ser_t         SER,
	output logic                      IRQ
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;

	// ****************************************
	// Registers and state
	// ****************************************
	logic [15:0]          div_reg, cfg_reg, ctl_reg;
	logic [5:0]           stat_reg, mask_reg;
	logic [15:0]          rdata_next;
	logic [7:0]           tx_mem [DEPTH];
	logic [7:0]           rx_mem [DEPTH];
	logic [PW-1:0]        tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
	logic [CW-1:0]        tx_cnt_reg, rx_cnt_reg, tx_cnt_next, rx_cnt_next;
	logic [2:0]           done_cnt_reg;
	sdc_pkg::sdc_state_t  state_reg;
	logic [7:0]           tx_sh_reg, rx_sh_reg, last_reg;
	logic [2:0]           bit_reg;
	logic [5:0]           hc_reg;
	logic                 sclk_reg, cs_n_reg;

	// ****************************************
	// Decode
	// ****************************************
	wire       wr_tx     = BUS.wr && BUS.addr == sdc_pkg::OFS_TX_DATA;
	wire       wr_div    = BUS.wr && BUS.addr == sdc_pkg::OFS_DIV_CTRL;
	wire       wr_cfg    = BUS.wr && BUS.addr == sdc_pkg::OFS_UNIT_CFG;
	wire       wr_ctl    = BUS.wr && BUS.addr == sdc_pkg::OFS_UNIT_CTRL;
	wire       wr_stat   = BUS.wr && BUS.addr == sdc_pkg::OFS_STATUS;
	wire       wr_mask   = BUS.wr && BUS.addr == sdc_pkg::OFS_MASK;
	wire       rd_pop    = BUS.rd && BUS.addr == sdc_pkg::OFS_RX_POP;

	wire       unit_en   = ctl_reg[sdc_pkg::CTL_ENABLE];
	wire       dma_en    = ctl_reg[sdc_pkg::CTL_DMA];
	wire       hspeed    = ctl_reg[sdc_pkg::CTL_HSPEED];
	wire       tx_purge  = cfg_reg[sdc_pkg::CFG_TX_PURGE];
	wire       rx_purge  = cfg_reg[sdc_pkg::CFG_RX_PURGE];
	wire       continuous_mode_mode = cfg_reg[sdc_pkg::CFG_CONTINUOUS_MODE];
	wire       zero_fill = cfg_reg[sdc_pkg::CFG_ZERO_FILL];
	wire       restart   = div_reg[sdc_pkg::DIV_RESTART];
	wire [5:0] divisor   = div_reg[5:0];
	wire [2:0] thr       = {1'b0, cfg_reg[sdc_pkg::CFG_THR_HI:sdc_pkg::CFG_THR_LO]} + 3'h1;

	// Edge interrupts only in continuous plus high-speed mode
	wire       edge_gate = div_reg[sdc_pkg::DIV_EDGE_IRQ] && continuous_mode_mode && hspeed;
	wire       cs_rise   = CS_N && !cs_n_reg;
	wire       cs_fall   = !CS_N && cs_n_reg;

	// ****************************************
	// Transmit FIFO push
	// ****************************************
	wire [CW-1:0] push_n   = dma_en ? CW'(2) : CW'(1);
	wire          tx_room  = (tx_cnt_reg + push_n) <= CW'(DEPTH);
	wire          tx_push  = wr_tx && !tx_purge && tx_room;
	wire          tx_empty = tx_cnt_reg == '0;

	// ****************************************
	// Serial engine decode
	// ****************************************
	wire       load     = state_reg == sdc_pkg::SH_IDLE && unit_en && !CS_N;
	// Purge forces the fill byte even before the count has cleared
	wire       use_fill = tx_empty || tx_purge;
	wire       tx_pop   = load && !use_fill;
	wire       under    = load && use_fill;
	wire [7:0] fill     = zero_fill ? 8'h00 : last_reg;
	wire       shifting = state_reg == sdc_pkg::SH_SHIFT && !CS_N;
	wire       half     = shifting && hc_reg >= divisor;
	wire       rise_ev  = half && !sclk_reg;
	wire       fall_ev  = half && sclk_reg;
	wire       byte_end = fall_ev && bit_reg == sdc_pkg::LAST_BIT;
	wire       sel_err  = cs_rise && state_reg == sdc_pkg::SH_SHIFT;

	// ****************************************
	// Receive FIFO
	// ****************************************
	wire       rx_full  = rx_cnt_reg == CW'(DEPTH);
	wire       rx_push  = byte_end && !rx_purge && !rx_full;
	wire       rx_pop   = rd_pop && rx_cnt_reg != '0 && !rx_purge;
	// Empty FIFO reads zero, never a stale entry
	wire [7:0] rx_head  = rx_cnt_reg == '0 ? 8'h00 : rx_mem[rx_rp_reg];

	assign tx_cnt_next = tx_purge ? '0 :
		tx_cnt_reg + (tx_push ? push_n : CW'(0)) - (tx_pop ? CW'(1) : CW'(0));
	assign rx_cnt_next = rx_purge ? '0 :
		rx_cnt_reg + (rx_push ? CW'(1) : CW'(0)) - (rx_pop ? CW'(1) : CW'(0));

	// ****************************************
	// Events, sticky status, interrupt
	// ****************************************
	wire       done_hit = byte_end && (done_cnt_reg + 3'h1) >= thr;
	wire       rx_hit   = {1'b0, rx_cnt_reg} >= {1'b0, thr} || rx_full;
	wire [5:0] ev_set;
	assign ev_set[sdc_pkg::ST_TX_THR]    = done_hit && !rx_purge;
	assign ev_set[sdc_pkg::ST_RX_THR]    = rx_hit && !rx_purge;
	assign ev_set[sdc_pkg::ST_UNDERFLOW] = under;
	assign ev_set[sdc_pkg::ST_SEL_RISE]  = cs_rise && edge_gate && !rx_purge;
	assign ev_set[sdc_pkg::ST_SEL_FALL]  = cs_fall && edge_gate && !rx_purge;
	assign ev_set[sdc_pkg::ST_SEL_ERR]   = sel_err && !rx_purge;

	// Set wins over a same-cycle write-one clear
	wire [5:0] stat_next = (stat_reg & ~(wr_stat ? BUS.wdata[5:0] : 6'h00)) | ev_set;
	wire [5:0] irq_src   = stat_reg & mask_reg &
		~(tx_purge ? 6'h04 : 6'h00);
	assign IRQ = !rx_purge && |irq_src;

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rdata_next = 16'h0000;
		if (BUS.rd) begin
			case (BUS.addr)
				sdc_pkg::OFS_DIV_CTRL:  rdata_next = div_reg & sdc_pkg::DIV_RW_MASK;
				sdc_pkg::OFS_UNIT_CFG:  rdata_next = cfg_reg;
				sdc_pkg::OFS_UNIT_CTRL: rdata_next = ctl_reg;
				sdc_pkg::OFS_STATUS: begin
					rdata_next[5:0] = stat_reg;
					rdata_next[sdc_pkg::ST_TXCNT_LO +: CW] = tx_cnt_reg;
					rdata_next[sdc_pkg::ST_RXCNT_LO +: CW] = rx_cnt_reg;
				end
				sdc_pkg::OFS_MASK:      rdata_next = {10'h000, mask_reg};
				sdc_pkg::OFS_RX_POP:    rdata_next = {8'h00, rx_head};
				default:                rdata_next = 16'h0000;
			endcase
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			div_reg  <= sdc_pkg::REG_RESET;
			cfg_reg  <= sdc_pkg::REG_RESET;
			ctl_reg  <= sdc_pkg::REG_RESET;
			stat_reg <= sdc_pkg::ST_RESET;
			mask_reg <= sdc_pkg::ST_RESET;
			RDATA    <= 16'h0000;
		end else begin
			if (wr_div) div_reg <= BUS.wdata & sdc_pkg::DIV_RW_MASK;
			if (wr_cfg) cfg_reg <= BUS.wdata;
			if (wr_ctl) ctl_reg <= {13'h0000, BUS.wdata[2:0]};
			if (wr_mask) mask_reg <= BUS.wdata[5:0];
			stat_reg <= stat_next;
			RDATA    <= rdata_next;
		end
	end

	// ****************************************
	// FIFO storage and pointers
	// ****************************************
	// Pointers wrap naturally, hence the power-of-two depth
	always_ff @(posedge CLK_SYS) begin
		if (tx_push) begin
			tx_mem[tx_wp_reg] <= BUS.wdata[7:0];
			if (dma_en) tx_mem[tx_wp_reg + PW'(1)] <= BUS.wdata[15:8];
		end
		if (rx_push) rx_mem[rx_wp_reg] <= rx_sh_reg;
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			tx_wp_reg  <= '0;
			tx_rp_reg  <= '0;
			tx_cnt_reg <= '0;
			rx_wp_reg  <= '0;
			rx_rp_reg  <= '0;
			rx_cnt_reg <= '0;
		end else begin
			tx_cnt_reg <= tx_cnt_next;
			rx_cnt_reg <= rx_cnt_next;
			if (tx_purge) begin
				tx_wp_reg <= '0;
				tx_rp_reg <= '0;
			end else begin
				if (tx_push) tx_wp_reg <= tx_wp_reg + push_n[PW-1:0];
				if (tx_pop) tx_rp_reg <= tx_rp_reg + PW'(1);
			end
			if (rx_purge) begin
				rx_wp_reg <= '0;
				rx_rp_reg <= '0;
			end else begin
				if (rx_push) rx_wp_reg <= rx_wp_reg + PW'(1);
				if (rx_pop) rx_rp_reg <= rx_rp_reg + PW'(1);
			end
		end
	end

	// ****************************************
	// Serial engine
	// ****************************************
	// Engine pauses when select is released mid-byte with restart clear
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state_reg    <= sdc_pkg::SH_IDLE;
			tx_sh_reg    <= 8'h00;
			rx_sh_reg    <= 8'h00;
			last_reg     <= 8'h00;
			bit_reg      <= 3'h0;
			hc_reg       <= 6'h00;
			sclk_reg     <= 1'b0;
			cs_n_reg     <= 1'b1;
			done_cnt_reg <= 3'h0;
		end else begin
			cs_n_reg <= CS_N;
			if (byte_end) done_cnt_reg <= done_hit ? 3'h0 : done_cnt_reg + 3'h1;
			case (state_reg)
				sdc_pkg::SH_IDLE: begin
					if (load) begin
						tx_sh_reg <= use_fill ? fill : tx_mem[tx_rp_reg];
						last_reg  <= use_fill ? fill : tx_mem[tx_rp_reg];
						state_reg <= sdc_pkg::SH_SHIFT;
						bit_reg   <= 3'h0;
						hc_reg    <= 6'h00;
					end
				end
				sdc_pkg::SH_SHIFT: begin
					if (sel_err && restart) begin
						state_reg <= sdc_pkg::SH_IDLE;
						bit_reg   <= 3'h0;
						sclk_reg  <= 1'b0;
					end else if (shifting) begin
						hc_reg <= half ? 6'h00 : hc_reg + 6'h01;
						if (half) sclk_reg <= !sclk_reg;
						if (rise_ev && !rx_purge) rx_sh_reg <= {rx_sh_reg[6:0], MISO};
						if (byte_end) begin
							state_reg <= sdc_pkg::SH_IDLE;
						end else if (fall_ev) begin
							bit_reg   <= bit_reg + 3'h1;
							tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
						end
					end
				end
				default: state_reg <= sdc_pkg::SH_IDLE;
			endcase
		end
	end

	assign SER.sclk = sclk_reg;
	assign SER.mosi = tx_sh_reg[7];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	a_dma_pair_push: assert property (tx_push && dma_en && !tx_pop |=> tx_cnt_reg == $past(tx_cnt_reg) + CW'(2))
		else $error("DMA write did not add two bytes");
	a_divider_period: assert property ($past(state_reg == sdc_pkg::SH_SHIFT) && $changed(sclk_reg) && !$past(sel_err)
		|-> $past(hc_reg) >= $past(divisor))
		else $error("Serial clock toggled before the divisor count");
	a_edge_flag_set: assert property (cs_rise && edge_gate && !rx_purge |=> stat_reg[sdc_pkg::ST_SEL_RISE])
		else $error("Select rise not flagged");
	a_edge_quiet: assert property (!edge_gate && !stat_reg[sdc_pkg::ST_SEL_FALL] |=> !stat_reg[sdc_pkg::ST_SEL_FALL])
		else $error("Select fall flagged while disabled");
	a_err_restart: assert property (sel_err && restart |=> state_reg == sdc_pkg::SH_IDLE && bit_reg == 3'h0)
		else $error("Bit counter not reset after select error");
	a_err_resume: assert property (sel_err && !restart |=> bit_reg == $past(bit_reg) && state_reg == sdc_pkg::SH_SHIFT)
		else $error("Bit counter moved after select error");
	a_rx_thr_flag: assert property (rx_hit && !rx_purge |=> stat_reg[sdc_pkg::ST_RX_THR])
		else $error("Receive threshold not flagged");
	a_tx_purge_empty: assert property (tx_purge |=> tx_cnt_reg == '0 && tx_wp_reg == '0 && tx_rp_reg == '0)
		else $error("Transmit FIFO not empty under purge");
	a_purge_fill: assert property (load && tx_purge && zero_fill |=> tx_sh_reg == 8'h00)
		else $error("Purge did not send zero fill");
	a_purge_drop: assert property (tx_purge && wr_tx |=> tx_cnt_reg == '0)
		else $error("Write accepted under purge");
	a_rx_purge_quiet: assert property (rx_purge |-> !IRQ ##1 rx_cnt_reg == '0)
		else $error("Receive purge left data or interrupt");
	a_repeat_last: assert property (load && tx_empty && !zero_fill |=> tx_sh_reg == $past(last_reg))
		else $error("Empty FIFO did not repeat last byte");
	a_underflow_set: assert property (under |=> stat_reg[sdc_pkg::ST_UNDERFLOW])
		else $error("Underflow not flagged");

	// ****************************************
	// Further checks
	// ****************************************
	a_tx_reads_zero: assert property ($past(BUS.rd) && $past(BUS.addr) == sdc_pkg::OFS_TX_DATA |-> RDATA == 16'h0000)
		else $error("Transmit register read back nonzero");
	a_dma_off_single: assert property (tx_push && !dma_en && !tx_pop |=> tx_cnt_reg == $past(tx_cnt_reg) + CW'(1))
		else $error("Plain write did not add one byte");
	a_div_low_bits: assert property (wr_div |=> divisor == $past(BUS.wdata[5:0]))
		else $error("Divisor not taken from low bits");
	a_sclk_idle: assert property (state_reg == sdc_pkg::SH_IDLE |-> !SER.sclk)
		else $error("Serial clock high while idle");
	a_edge_fall_flag: assert property (cs_fall && edge_gate && !rx_purge |=> stat_reg[sdc_pkg::ST_SEL_FALL])
		else $error("Select fall not flagged");
	a_rise_quiet: assert property (!edge_gate && !stat_reg[sdc_pkg::ST_SEL_RISE] |=> !stat_reg[sdc_pkg::ST_SEL_RISE])
		else $error("Select rise flagged while disabled");
	a_idle_enable: assert property (state_reg == sdc_pkg::SH_IDLE && !unit_en |=> state_reg == sdc_pkg::SH_IDLE)
		else $error("Engine started while unit disabled");
	a_resume_paused: assert property (state_reg == sdc_pkg::SH_SHIFT && CS_N && !(sel_err && restart)
		|=> bit_reg == $past(bit_reg) && tx_sh_reg == $past(tx_sh_reg))
		else $error("Paused byte moved while select released");
	a_thr_tx_flag: assert property (done_hit && !rx_purge |=> stat_reg[sdc_pkg::ST_TX_THR])
		else $error("Transmit threshold not flagged");
	a_rx_full_flag: assert property (rx_full && !rx_purge |=> stat_reg[sdc_pkg::ST_RX_THR])
		else $error("Full receive FIFO not flagged");
	a_purge_hold: assert property (tx_purge && $past(tx_purge) |-> tx_cnt_reg == '0)
		else $error("Transmit count nonzero under held purge");
	a_rx_no_flush: assert property (!rx_purge && !rx_pop |=> rx_cnt_reg >= $past(rx_cnt_reg))
		else $error("Receive count dropped without purge");
	a_rx_shift_hold: assert property (rx_purge |=> rx_sh_reg == $past(rx_sh_reg))
		else $error("Serial input taken under receive purge");
	a_rx_pop_purge: assert property (rx_purge && rd_pop |=> rx_rp_reg == '0)
		else $error("Receive pointer moved under purge");
	a_fill_zero: assert property (load && tx_empty && zero_fill |=> tx_sh_reg == 8'h00)
		else $error("Empty FIFO did not send zero fill");
	a_purge_no_under: assert property (tx_purge && (stat_reg & mask_reg) == 6'h04 |-> !IRQ)
		else $error("Underflow interrupt under transmit purge");
	a_under_irq: assert property (stat_reg[sdc_pkg::ST_UNDERFLOW] && mask_reg[sdc_pkg::ST_UNDERFLOW] && !tx_purge
		&& !rx_purge |-> IRQ)
		else $error("Underflow raised no interrupt");

	// ****************************************
	// Covers
	// ****************************************
	c_dma_write:  cover property (tx_push && dma_en);
	c_sel_resume: cover property (sel_err && !restart);
	c_sel_error:  cover property (sel_err ##1 !CS_N);
	c_underflow:  cover property (under && zero_fill);
	c_rx_thresh:  cover property (ev_set[sdc_pkg::ST_RX_THR] && thr == 3'h4);

endmodule

/* File: dv/sdc_dev_model.sv */
// Purpose: Serial-side device model: drives select and MISO, captures MOSI bytes
// Assumes: Mode 0, MSB first; select follows the bench's request
// Notes:   Measures the high phase of the serial clock in system cycles

`timescale 1ns/1ps

module sdc_dev_model (
	input  wire logic              clk,
	input  wire logic              sel,
	input  wire logic              keep,
	input  wire logic [7:0]        pat,
	input  wire sdc_pkg::sdc_ser_t ser,
	output logic                   cs_n,
	output logic                   miso,
	output logic [7:0]             got,
	output int                     nbytes,
	output int                     hi_len
);
	// ****************************************
	// Shifting and capture
	// ****************************************
	logic [7:0] rsh;
	logic [7:0] tsh;
	logic       tog;
	int         bitc;
	int         run;

	assign cs_n = ~sel;
	// Released line toggles so a stale bit cannot pass for data
	assign miso = cs_n ? tog : tsh[7];

	initial begin
		{rsh, tsh, got, tog} = 25'h0;
		{bitc, run, nbytes, hi_len} = 128'h0;
	end

	always @(posedge clk) begin
		tog <= ~tog;
		if (ser.sclk) begin
			run <= run + 1;
		end else begin
			if (run != 0) begin
				hi_len <= run;
			end
			run <= 0;
		end
	end

	// Keep set: a select gap resumes the byte instead of starting afresh
	always @(negedge cs_n) begin
		if (!keep) begin
			tsh = pat;
			bitc = 0;
		end
	end

	always @(negedge ser.sclk) begin
		if (!cs_n) begin
			tsh = tsh << 1;
		end
	end

	always @(posedge ser.sclk) begin
		if (!cs_n) begin
			rsh = {rsh[6:0], ser.mosi};
			bitc = bitc + 1;
			if (bitc == 8) begin
				got = rsh;
				nbytes = nbytes + 1;
				bitc = 0;
			end
		end
	end
endmodule

/* File: dv/sdc_top_bench.sv */
// Purpose: Self-checking bench for the transmit, divider and configuration slice
// Assumes: Device model on the serial side, reset held 12 cycles
// Notes:   Each scenario drives and judges before it returns

`timescale 1ns/1ps

module sdc_top_bench;
	localparam logic [31:0] TX = sdc_pkg::OFS_TX_DATA;
	localparam logic [31:0] DV = sdc_pkg::OFS_DIV_CTRL;
	localparam logic [31:0] CF = sdc_pkg::OFS_UNIT_CFG;
	localparam logic [31:0] CT = sdc_pkg::OFS_UNIT_CTRL;
	localparam logic [31:0] ST = sdc_pkg::OFS_STATUS;
	localparam logic [31:0] MK = sdc_pkg::OFS_MASK;
	localparam logic [31:0] RX = sdc_pkg::OFS_RX_POP;

	logic                  clk_sys;
	logic                  rst;
	logic                  cs_n;
	logic                  miso;
	logic                  irq;
	logic                  sel;
	logic                  keep;
	sdc_pkg::sdc_bus_req_t bus;
	sdc_pkg::sdc_ser_t     ser;
	logic [15:0]           rdata;
	logic [15:0]           v;
	logic [7:0]            pat;
	logic [7:0]            got;
	int                    nbytes;
	int                    hi_len;
	int                    n_fail;
	int                    total_checks;

	sdc_top sdc_top_i (.CLK_SYS(clk_sys), .RST(rst), .BUS(bus), .RDATA(rdata), .CS_N(cs_n), .MISO(miso),
		.SER(ser), .IRQ(irq));
	sdc_dev_model sdc_dev_model_i (.clk(clk_sys), .sel(sel), .pat(pat), .ser(ser), .cs_n(cs_n), .miso(miso),
		.keep(keep), .got(got), .nbytes(nbytes), .hi_len(hi_len));

	initial begin
		clk_sys = 1'h0;
		forever #4 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'h1;
		@(posedge clk_sys);
		bus.wr <= 1'h0;
	endtask

	task automatic rd(input logic [31:0] a);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.rd <= 1'h1;
		@(posedge clk_sys);
		bus.rd <= 1'h0;
		@(negedge clk_sys);
		v = rdata;
	endtask

	// Drops select on the edge of the last falling serial clock, so no fill byte follows
	task automatic send(input int d);
		int n0;
		n0 = nbytes;
		@(posedge clk_sys);
		sel <= 1'h1;
		for (int i = 0; i < 3000 && nbytes == n0; i++) @(negedge clk_sys);
		if (nbytes == n0) begin
			n_fail++;
			$display("wrong value at %0t: no byte seen", $time);
			give_verdict();
		end
		repeat (d + 1) @(posedge clk_sys);
		sel <= 1'h0;
		@(posedge clk_sys);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		rd(TX); check(v, 16'h0000);
		rd(DV); check(v, 16'h0000);
		wr(DV, 16'hffff);
		rd(DV); check(v, 16'h01ff);
		wr(CF, 16'hc0a5);
		rd(CF); check(v, 16'hc0a5);
		wr(CF, 16'h0000);
		wr(32'h40030014, 16'hffff);
		rd(32'h40030014); check(v, 16'h0000);
		rd(CF); check(v, 16'h0000);
	endtask

	task automatic t_tx;
		wr(CT, 16'h0001);
		wr(DV, 16'h0083);
		wr(ST, 16'h003f);
		wr(TX, 16'hab5c);
		rd(ST); check(16'(v[10:8]), 16'h0001);
		send(3); check(16'(got), 16'h005c);
		check(16'(hi_len), 16'h0004);
		rd(ST); check(16'(v[1:0]), 16'h0003);
		rd(RX); check(v, 16'h00a5);
	endtask

	task automatic t_dma;
		wr(CT, 16'h0003);
		wr(DV, 16'h0080);
		wr(CF, 16'h0000);
		wr(TX, 16'h1234);
		rd(ST); check(16'(v[10:8]), 16'h0002);
		send(0); check(16'(got), 16'h0034);
		send(0); check(16'(got), 16'h0012);
	endtask

	task automatic t_thr;
		wr(CT, 16'h0001);
		wr(CF, 16'h4000);
		wr(ST, 16'h003f);
		wr(TX, 16'h0077);
		wr(TX, 16'h0088);
		send(0); rd(ST); check(16'(v[0]), 16'h0000);
		send(0); rd(ST); check(16'(v[0]), 16'h0001);
		check(16'(got), 16'h0088);
	endtask

	task automatic t_fill;
		wr(CF, 16'h0000);
		wr(MK, 16'h0004);
		wr(ST, 16'h003f);
		send(0); check(16'(got), 16'h0088);
		rd(ST); check(16'(v[2]), 16'h0001);
		check(16'(irq), 16'h0001);
		wr(CF, 16'h0080);
		send(0); check(16'(got), 16'h0000);
		wr(CF, 16'h2080);
		wr(TX, 16'h0055);
		rd(ST); check(16'(v[10:8]), 16'h0000);
		check(16'(irq), 16'h0000);
		send(0); check(16'(got), 16'h0000);
		wr(CF, 16'h0000);
		wr(ST, 16'h003f);
		wr(TX, 16'h0066);
		send(0); check(16'(got), 16'h0066);
	endtask

	task automatic t_rxpurge;
		wr(MK, 16'h003f);
		wr(CF, 16'h1000);
		send(0); check(16'(irq), 16'h0000);
		rd(ST); check(16'(v[14:12]), 16'h0000);
		rd(RX); check(v, 16'h0000);
		wr(CF, 16'h0000);
		wr(MK, 16'h0018);
	endtask

	task automatic t_sel;
		wr(CT, 16'h0005);
		wr(CF, 16'h0800);
		wr(DV, 16'h0100);
		wr(ST, 16'h003f);
		send(0); rd(ST); check(16'(v[4:3]), 16'h0003);
		check(16'(irq), 16'h0001);
		wr(DV, 16'h0000);
		wr(ST, 16'h003f);
		send(0); rd(ST); check(16'(v[4:3]), 16'h0000);
		wr(CT, 16'h0001);
		wr(DV, 16'h0100);
		send(0); rd(ST); check(16'(v[4:3]), 16'h0000);
		wr(MK, 16'h0000);
	endtask

	// Abort mid-byte; restart must begin the next byte from its first bit
	task automatic t_err;
		wr(DV, 16'h0083);
		wr(CF, 16'h0000);
		wr(ST, 16'h003f);
		wr(TX, 16'h00c3);
		wr(TX, 16'h003c);
		@(posedge clk_sys);
		sel <= 1'h1;
		repeat (10) @(posedge clk_sys);
		sel <= 1'h0;
		rd(ST); check(16'(v[5]), 16'h0001);
		wr(CT, 16'h0000);
		wr(CT, 16'h0001);
		send(3); check(16'(got), 16'h003c);
	endtask

	// Abort mid-byte without restart; the byte must finish after select returns
	task automatic t_resume;
		wr(DV, 16'h0003);
		wr(ST, 16'h003f);
		wr(TX, 16'h005a);
		keep <= 1'h1;
		@(posedge clk_sys);
		sel <= 1'h1;
		repeat (10) @(posedge clk_sys);
		sel <= 1'h0;
		rd(ST); check(16'(v[5]), 16'h0001);
		send(3); check(16'(got), 16'h005a);
		keep <= 1'h0;
	endtask

	initial begin
		rst = 1'h1;
		bus = 50'h0;
		sel = 1'h0;
		keep = 1'h0;
		pat = 8'ha5;
		n_fail = 0;
		total_checks = 0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'h0;
		t_regs();
		t_tx();
		t_dma();
		t_thr();
		t_fill();
		t_rxpurge();
		t_sel();
		t_err();
		t_resume();
		give_verdict();
	end
endmodule
